// file: dv/rss_board_model.sv
`timescale 1ns/10ps
// Board side: supply monitor, management controller and strap resistors
module rss_board_model (
   input wire logic supply_ok,
   input wire logic por_req_n,
   input wire logic park_req_n,
   input wire logic [rss_pkg::STRAP_COUNT-1:0] strap_pullup,
   input wire logic [rss_pkg::STRAP_COUNT-1:0] pin_out,
   input wire logic [rss_pkg::STRAP_COUNT-1:0] pin_oe,
   input wire logic [rss_pkg::STRAP_COUNT-1:0] pin_pd,
   input wire logic [6:0] grp_drv,
   output logic [6:0] grp_level,
   output logic por_n,
   output logic park_n,
   output logic [rss_pkg::STRAP_COUNT-1:0] strap_level
);
   import rss_pkg::*;
   // Reset pin stays low until supplies and clocks have settled
   assign por_n = supply_ok & por_req_n;
   // Controller parks at once when supply looks lost
   assign park_n = supply_ok & park_req_n;
   // Board pulldowns own the driven-low group until the device is powered
   assign grp_level = supply_ok ? grp_drv : 7'h00;
   // Device drive wins; strong pullup beats the weak pulldown; no pulldown reads high
   assign strap_level = (pin_oe & pin_out) | (~pin_oe & (strap_pullup | ~pin_pd));
endmodule

// file: dv/rss_top_chk.sv
`timescale 1ns/10ps
// Port-level checks of the reset and strap sequencer
module rss_top_chk
   import rss_pkg::*;
#(
   parameter int unsigned GP_WIDTH = 8
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic PARK_REQUEST_N,
   input wire logic FLASH_DIAG_CHECKSUM,
   input wire logic [3:0] ILLUM_SELECT,
   input wire logic MIRROR_ARRAY_RESET_N,
   input wire logic MONITOR_ADC_CLOCK,
   input wire logic MONITOR_ADC_DATA_OUT,
   input wire logic [GP_WIDTH-1:0] GP_OE,
   input wire logic [rss_pkg::STRAP_COUNT-1:0] STRAP_OE,
   input wire logic [rss_pkg::STRAP_COUNT-1:0] STRAP_PULLDOWN_EN,
   input wire logic INIT_START,
   input wire logic STRAPS_VALID,
   input wire logic MIRROR_PARK,
   input wire logic HOST_PORT_TWO_WIRE,
   input wire logic DIAG_PORT_TWO_WIRE,
   input wire logic SPI_CLOCK_MODE_ALT,
   input wire logic INTEGRITY_METHOD_SELECT,
   input wire logic DIAG_INTEGRITY_CHECKSUM
);
   // One clock domain, block reset disables every check
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);

   // Start pulse and STRAPS_VALID rising 31 cycles on
   a_init_pulse: assert property (INIT_START |=> !INIT_START)
      else $error("init pulse longer than one cycle");
   a_sample_time: assert property (INIT_START |-> ##30 !STRAPS_VALID ##1 STRAPS_VALID)
      else $error("strap sample not 1.5us after release");
   // Pins stay quiet until the straps are in
   a_group_low: assert property (!STRAPS_VALID |-> {ILLUM_SELECT, MIRROR_ARRAY_RESET_N,
      MONITOR_ADC_CLOCK, MONITOR_ADC_DATA_OUT} == 7'h00)
      else $error("driven-low group not low");
   a_gp_float: assert property (!STRAPS_VALID |-> GP_OE == '0)
      else $error("general pin driven in reset");
   a_strap_quiet: assert property (|STRAP_OE |-> STRAPS_VALID)
      else $error("strap pin driven before sample");
   a_pulldown_on: assert property (STRAP_PULLDOWN_EN == STRAP_PULLDOWN_ON)
      else $error("strap pulldown off");
   // Latched straps and their decode
   a_straps_hold: assert property (STRAPS_VALID && $past(STRAPS_VALID) |-> $stable(
      {HOST_PORT_TWO_WIRE, SPI_CLOCK_MODE_ALT, INTEGRITY_METHOD_SELECT}))
      else $error("latched strap changed");
   a_diag_port: assert property (STRAPS_VALID |->
      DIAG_PORT_TWO_WIRE == !HOST_PORT_TWO_WIRE)
      else $error("diag port not the other port");
   a_diag_integ: assert property (STRAPS_VALID && $past(STRAPS_VALID) |->
      DIAG_INTEGRITY_CHECKSUM == $past(FLASH_DIAG_CHECKSUM))
      else $error("diag integrity not from flash");
   // Park follows the pin within the sync delay
   a_park_set: assert property ($fell(PARK_REQUEST_N) ##1 !PARK_REQUEST_N [*3]
      |=> MIRROR_PARK)
      else $error("park not taken");
   a_park_clr: assert property ($rose(PARK_REQUEST_N) ##1 PARK_REQUEST_N [*3]
      |=> !MIRROR_PARK)
      else $error("un-park not taken");

   c_init: cover property (INIT_START);
   c_two_wire: cover property ($rose(STRAPS_VALID) && HOST_PORT_TWO_WIRE);
   c_park: cover property ($rose(MIRROR_PARK));
endmodule

bind rss_top rss_top_chk #(.GP_WIDTH(GP_WIDTH)) u_chk (.CLK(CLK), .RESETN(RESETN),
   .PARK_REQUEST_N(PARK_REQUEST_N), .FLASH_DIAG_CHECKSUM(FLASH_DIAG_CHECKSUM),
   .ILLUM_SELECT(ILLUM_SELECT), .MIRROR_ARRAY_RESET_N(MIRROR_ARRAY_RESET_N),
   .MONITOR_ADC_CLOCK(MONITOR_ADC_CLOCK), .MONITOR_ADC_DATA_OUT(MONITOR_ADC_DATA_OUT),
   .GP_OE(GP_OE), .STRAP_OE(STRAP_OE), .STRAP_PULLDOWN_EN(STRAP_PULLDOWN_EN),
   .INIT_START(INIT_START), .STRAPS_VALID(STRAPS_VALID), .MIRROR_PARK(MIRROR_PARK),
   .HOST_PORT_TWO_WIRE(HOST_PORT_TWO_WIRE), .DIAG_PORT_TWO_WIRE(DIAG_PORT_TWO_WIRE),
   .SPI_CLOCK_MODE_ALT(SPI_CLOCK_MODE_ALT), .INTEGRITY_METHOD_SELECT(INTEGRITY_METHOD_SELECT),
   .DIAG_INTEGRITY_CHECKSUM(DIAG_INTEGRITY_CHECKSUM));

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import rss_pkg::*;
   localparam int unsigned GPW = 4;
   logic CLK, RESETN, supply_ok, por_req_n, park_req_n, flash_ck, por_n, park_n;
   logic [2:0] pu, lvl, dbg_out, dbg_oe, s_out, s_oe, s_pd;
   logic [3:0] illum_req, illum;
   logic mar_req_n, mar_n, adc_c_req, adc_d_req, adc_c, adc_d;
   logic [GPW-1:0] gp_out_req, gp_oe_req, gp_out, gp_oe;
   logic in_reset, init_start, valid, park, host2w, diag2w, spi_alt, integ, diag_ck;
   logic [6:0] grp_lvl;
   // Last pattern has the host-port bit set so the mid-run reset clear can show
   logic [2:0] pus [4] = '{3'h0, 3'h7, 3'h2, 3'h5};
   int n_mismatch, check_count, cyc;

   rss_board_model board (.supply_ok(supply_ok), .por_req_n(por_req_n),
      .park_req_n(park_req_n), .strap_pullup(pu), .pin_out(s_out), .pin_oe(s_oe),
      .pin_pd(s_pd), .grp_drv({illum, mar_n, adc_c, adc_d}), .grp_level(grp_lvl),
      .por_n(por_n), .park_n(park_n), .strap_level(lvl));

   rss_top #(.GP_WIDTH(GPW)) DUT (.CLK(CLK), .RESETN(RESETN), .POWER_ON_RESET_N(por_n),
      .PARK_REQUEST_N(park_n), .ILLUM_SELECT_REQ(illum_req),
      .MIRROR_ARRAY_RESET_REQ_N(mar_req_n), .MONITOR_ADC_CLOCK_REQ(adc_c_req),
      .MONITOR_ADC_DATA_REQ(adc_d_req), .GP_OUT_REQ(gp_out_req), .GP_OE_REQ(gp_oe_req),
      .STRAP_IN(lvl), .STRAP_DEBUG_OUT(dbg_out), .STRAP_DEBUG_OE(dbg_oe),
      .FLASH_DIAG_CHECKSUM(flash_ck), .ILLUM_SELECT(illum), .MIRROR_ARRAY_RESET_N(mar_n),
      .MONITOR_ADC_CLOCK(adc_c), .MONITOR_ADC_DATA_OUT(adc_d), .GP_OUT(gp_out),
      .GP_OE(gp_oe), .STRAP_OUT(s_out), .STRAP_OE(s_oe), .STRAP_PULLDOWN_EN(s_pd),
      .IN_RESET(in_reset), .INIT_START(init_start), .STRAPS_VALID(valid),
      .MIRROR_PARK(park), .HOST_PORT_TWO_WIRE(host2w), .DIAG_PORT_TWO_WIRE(diag2w),
      .SPI_CLOCK_MODE_ALT(spi_alt), .INTEGRITY_METHOD_SELECT(integ),
      .DIAG_INTEGRITY_CHECKSUM(diag_ck));

   initial begin
      CLK = 0;
      forever #25 CLK = ~CLK;
   end

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 4000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Inputs always change 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   // Run requests all high so a leak past reset would show
   task automatic t_hold_reset();
      step(4);
      chk(in_reset, 1);
      chk(grp_lvl, 0);
      chk({illum, mar_n, adc_c, adc_d}, 0);
      chk(gp_oe, 0);
      chk(s_oe, 0);
      chk(s_pd, STRAP_PULLDOWN_ON);
      step(1);
      RESETN = 1;
      step(6);
      chk({in_reset, valid}, 2'b10);
      $display("hold reset done");
   endtask

   task automatic t_boot(input logic [2:0] p);
      int n;
      pu = p;
      supply_ok = 1;
      por_req_n = 0;
      step(5);
      chk({in_reset, valid, gp_oe}, {2'b10, 4'h0});
      por_req_n = 1;
      n = 0;
      while (init_start !== 1'b1 && n < 10) begin
         step(1);
         n++;
      end
      chk(n <= 4, 1);
      n = 0;
      while (valid !== 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      chk(n, 31);
      chk({host2w, diag2w}, {p[0], !p[0]});
      chk(spi_alt, p[1]);
      chk(integ, p[2]);
      step(2);
      chk({illum, mar_n, adc_c, adc_d}, 7'h7F);
      chk(s_oe, dbg_oe);
      chk(s_out, dbg_out);
      chk({gp_oe, gp_out}, {gp_oe_req, gp_out_req});
      pu = ~p;
      step(5);
      chk({host2w, spi_alt, integ}, {p[0], p[1], p[2]});
      $display("boot with straps %h done", p);
   endtask

   task automatic t_park();
      park_req_n = 0;
      step(4);
      chk(park, 1);
      park_req_n = 1;
      step(4);
      chk(park, 0);
      $display("park done");
   endtask

   // Diag integrity from flash, then a block reset mid-run clears the straps
   task automatic t_diag();
      flash_ck = 0;
      step(2);
      chk(diag_ck, 0);
      flash_ck = 1;
      step(2);
      chk(diag_ck, 1);
      RESETN = 0;
      step(3);
      chk({valid, host2w, park}, 3'b001);
      RESETN = 1;
      step(1);
      $display("diag and mid-run reset done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      RESETN = 0;
      supply_ok = 0;
      por_req_n = 1;
      park_req_n = 1;
      flash_ck = 1;
      pu = 3'h0;
      dbg_out = 3'h5;
      dbg_oe = 3'h7;
      illum_req = 4'hF;
      mar_req_n = 1;
      adc_c_req = 1;
      adc_d_req = 1;
      gp_out_req = 4'hF;
      gp_oe_req = 4'hF;
      n_mismatch = 0;
      check_count = 0;
      cyc = 0;
      t_hold_reset();
      foreach (pus[i]) t_boot(pus[i]);
      t_park();
      t_diag();
      results();
   end
endmodule

// file: hw/rss_pkg.sv
package rss_pkg;

   // Clock and strap sample timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned SAMPLE_DELAY_NS = 1500;
   // Nominal figure, so a plain division; 1500 ns is a whole number of 50 ns cycles
   localparam int unsigned SAMPLE_CYCLES = SAMPLE_DELAY_NS / CLK_PERIOD_NS;
   localparam int unsigned SAMPLE_CNT_W = 6;
   localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_LAST =
      SAMPLE_CNT_W'(SAMPLE_CYCLES - 1);
   localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_CNT_RESET = 6'h00;

   // Strap pin positions within the strap bus
   localparam int unsigned STRAP_COUNT = 3;
   localparam int unsigned STRAP_HOST_PORT = 0;
   localparam int unsigned STRAP_CLK_MODE = 1;
   localparam int unsigned STRAP_INTEGRITY = 2;
   localparam logic [STRAP_COUNT-1:0] STRAP_RESET_VAL = 3'h0;
   localparam logic [STRAP_COUNT-1:0] STRAP_PULLDOWN_ON = 3'h7;

   // Values held on the driven-low group and status outputs during reset
   localparam logic [3:0] ILLUM_RESET_VAL = 4'h0;
   localparam logic MIRROR_RESET_VAL = 1'h0;
   localparam logic ADC_RESET_VAL = 1'h0;
   localparam logic PARK_RESET_VAL = 1'h1;

   // Default width of the general output group that floats in reset
   localparam int unsigned GP_WIDTH_DEFAULT = 8;

   // Sequencer states, Gray coded along reset -> settle -> run
   typedef enum logic [1:0] {
      RSS_ST_RESET = 2'b00,
      RSS_ST_SETTLE = 2'b01,
      RSS_ST_RUN = 2'b11
   } rss_state_e;

endpackage

// file: hw/rss_strap_bank.sv
`timescale 1ns/10ps
module rss_strap_bank (
   input wire logic clk,
   input wire logic resetn,
   rss_strap_if.bank ctl,
   input wire logic [rss_pkg::STRAP_COUNT-1:0] pin_in,
   output logic [rss_pkg::STRAP_COUNT-1:0] pin_out,
   output logic [rss_pkg::STRAP_COUNT-1:0] pin_oe,
   output logic [rss_pkg::STRAP_COUNT-1:0] pulldown_en
);
   import rss_pkg::*;

   logic [STRAP_COUNT-1:0] sync1_reg;
   logic [STRAP_COUNT-1:0] sync2_reg;
   logic [STRAP_COUNT-1:0] value_reg;
   logic held_reg;
   logic [STRAP_COUNT-1:0] out_reg;
   logic [STRAP_COUNT-1:0] oe_reg;
   logic [STRAP_COUNT-1:0] pd_reg;
   logic [STRAP_COUNT-1:0] out_next;
   logic [STRAP_COUNT-1:0] oe_next;

   // Pins are asynchronous to CLK, so two flops before the latch reads them
   always_ff @(posedge clk) begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
   end

   // Latch once at the sample point, then ignore the pins until reset
   always_ff @(posedge clk) begin
      if (!resetn || ctl.clear) begin
         value_reg <= STRAP_RESET_VAL;
         held_reg <= 1'b0;
      end else if (ctl.sample && !held_reg) begin
         value_reg <= sync2_reg;
         held_reg <= 1'b1;
      end
   end

   // Debug drive only after the latch; held_reg lags the strobe by one edge
   assign oe_next = held_reg ? ctl.dbg_oe : STRAP_RESET_VAL;
   assign out_next = held_reg ? ctl.dbg_out : STRAP_RESET_VAL;

   // Output stage; the weak pulldown stays enabled so an open pin reads 0
   always_ff @(posedge clk) begin
      if (!resetn || ctl.clear) begin
         out_reg <= STRAP_RESET_VAL;
         oe_reg <= STRAP_RESET_VAL;
         pd_reg <= STRAP_PULLDOWN_ON;
      end else begin
         out_reg <= out_next;
         oe_reg <= oe_next;
         pd_reg <= STRAP_PULLDOWN_ON;
      end
   end

   assign ctl.value = value_reg;
   assign ctl.held = held_reg;
   assign pin_out = out_reg;
   assign pin_oe = oe_reg;
   assign pulldown_en = pd_reg;

endmodule

// file: hw/rss_strap_if.sv
`timescale 1ns/10ps
// Carries sample control and latched strap values between sequencer and strap bank
interface rss_strap_if;
   import rss_pkg::*;
   logic sample;
   logic clear;
   logic held;
   logic [STRAP_COUNT-1:0] value;
   logic [STRAP_COUNT-1:0] dbg_out;
   logic [STRAP_COUNT-1:0] dbg_oe;
   modport bank (
      input sample,
      input clear,
      input dbg_out,
      input dbg_oe,
      output held,
      output value
   );
   modport ctrl (
      output sample,
      output clear,
      output dbg_out,
      output dbg_oe,
      input held,
      input value
   );
endinterface

// file: hw/rss_top.sv
`timescale 1ns/10ps
// Operation
// - Low input holds reset; rise starts initialization
// - Illumination, mirror reset, monitor lines driven low
// - All other outputs tristated during reset
// - Park input low parks mirrors, high un-parks
// - Host-port strap picks SPI or two-wire
// - Clock-mode strap picks SPI modes 0/3, 1/2
// - Integrity strap picks CRC or checksum, host only
// - Straps float in reset, sampled 1.5us later
// - Strap pins drive debug only after sampling
// - Weak pulldown makes open strap read zero
module rss_top #(
   parameter int unsigned GP_WIDTH = rss_pkg::GP_WIDTH_DEFAULT
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic POWER_ON_RESET_N,
   input wire logic PARK_REQUEST_N,
   input wire logic [3:0] ILLUM_SELECT_REQ,
   input wire logic MIRROR_ARRAY_RESET_REQ_N,
   input wire logic MONITOR_ADC_CLOCK_REQ,
   input wire logic MONITOR_ADC_DATA_REQ,
   input wire logic [GP_WIDTH-1:0] GP_OUT_REQ,
   input wire logic [GP_WIDTH-1:0] GP_OE_REQ,
   input wire logic [rss_pkg::STRAP_COUNT-1:0] STRAP_IN,
   input wire logic [rss_pkg::STRAP_COUNT-1:0] STRAP_DEBUG_OUT,
   input wire logic [rss_pkg::STRAP_COUNT-1:0] STRAP_DEBUG_OE,
   input wire logic FLASH_DIAG_CHECKSUM,
   output logic [3:0] ILLUM_SELECT,
   output logic MIRROR_ARRAY_RESET_N,
   output logic MONITOR_ADC_CLOCK,
   output logic MONITOR_ADC_DATA_OUT,
   output logic [GP_WIDTH-1:0] GP_OUT,
   output logic [GP_WIDTH-1:0] GP_OE,
   output logic [rss_pkg::STRAP_COUNT-1:0] STRAP_OUT,
   output logic [rss_pkg::STRAP_COUNT-1:0] STRAP_OE,
   output logic [rss_pkg::STRAP_COUNT-1:0] STRAP_PULLDOWN_EN,
   output logic IN_RESET,
   output logic INIT_START,
   output logic STRAPS_VALID,
   output logic MIRROR_PARK,
   output logic HOST_PORT_TWO_WIRE,
   output logic DIAG_PORT_TWO_WIRE,
   output logic SPI_CLOCK_MODE_ALT,
   output logic INTEGRITY_METHOD_SELECT,
   output logic DIAG_INTEGRITY_CHECKSUM
);
   import rss_pkg::*;

   // Refuse widths the output group cannot serve, at elaboration rather than at run time
   if (GP_WIDTH < 1 || GP_WIDTH > 256) begin : g_bad_width
      $error("GP_WIDTH must lie between 1 and 256");
   end

   rss_strap_if strap_if ();

   logic por_sync1_reg;
   logic por_sync2_reg;
   logic park_sync1_reg;
   logic park_sync2_reg;
   rss_state_e state_reg;
   rss_state_e state_next;
   logic [SAMPLE_CNT_W-1:0] cnt_reg;
   logic [SAMPLE_CNT_W-1:0] cnt_next;

   logic [3:0] illum_reg;
   logic mirror_rst_n_reg;
   logic adc_clk_reg;
   logic adc_data_reg;
   logic [GP_WIDTH-1:0] gp_out_reg;
   logic [GP_WIDTH-1:0] gp_oe_reg;
   logic in_reset_reg;
   logic init_start_reg;
   logic valid_reg;
   logic park_reg;
   logic host_two_wire_reg;
   logic diag_two_wire_reg;
   logic clk_mode_reg;
   logic integrity_reg;
   logic diag_checksum_reg;

   // Both pins arrive from outside; double-flop them before any decode
   always_ff @(posedge CLK) begin
      por_sync1_reg <= POWER_ON_RESET_N;
      por_sync2_reg <= por_sync1_reg;
      park_sync1_reg <= PARK_REQUEST_N;
      park_sync2_reg <= park_sync1_reg;
   end

   // Reset decode and sequencer controls
   wire held_in_reset = !RESETN || !por_sync2_reg;
   wire release_edge = (state_reg == RSS_ST_RESET) && !held_in_reset;
   wire sample_point = (state_reg == RSS_ST_SETTLE) && (cnt_reg == SAMPLE_LAST);
   wire running = (state_reg == RSS_ST_RUN);
   // The pin only starts us after supplies and clocks are good, so no extra guard
   wire release_ok = release_edge;

   // Sequencer next state; a pin reset at any point forces a fresh sample
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      if (held_in_reset) begin
         state_next = RSS_ST_RESET;
         cnt_next = SAMPLE_CNT_RESET;
      end else begin
         unique case (state_reg)
            RSS_ST_RESET: begin
               if (release_ok) begin
                  state_next = RSS_ST_SETTLE;
                  cnt_next = SAMPLE_CNT_RESET;
               end
            end
            RSS_ST_SETTLE: begin
               if (sample_point) begin
                  state_next = RSS_ST_RUN;
               end else begin
                  cnt_next = cnt_reg + SAMPLE_CNT_W'(1);
               end
            end
            RSS_ST_RUN: begin
               state_next = RSS_ST_RUN;
            end
            default: begin
               state_next = RSS_ST_RESET;
               cnt_next = SAMPLE_CNT_RESET;
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         state_reg <= RSS_ST_RESET;
         cnt_reg <= SAMPLE_CNT_RESET;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // Strap bank control; the bank clears itself whenever reset is held
   assign strap_if.sample = sample_point;
   assign strap_if.clear = held_in_reset;
   assign strap_if.dbg_out = STRAP_DEBUG_OUT;
   assign strap_if.dbg_oe = STRAP_DEBUG_OE;

   rss_strap_bank u_strap_bank (
      .clk(CLK),
      .resetn(RESETN),
      .ctl(strap_if.bank),
      .pin_in(STRAP_IN),
      .pin_out(STRAP_OUT),
      .pin_oe(STRAP_OE),
      .pulldown_en(STRAP_PULLDOWN_EN)
   );

   // Decoded configuration from the latched straps
   wire host_two_wire = strap_if.value[STRAP_HOST_PORT];
   wire clk_mode_alt = strap_if.value[STRAP_CLK_MODE];
   wire checksum_sel = strap_if.value[STRAP_INTEGRITY];

   // Driven-low group: forced low until the core is running, never floated
   always_ff @(posedge CLK) begin
      if (held_in_reset || !running) begin
         illum_reg <= ILLUM_RESET_VAL;
         mirror_rst_n_reg <= MIRROR_RESET_VAL;
         adc_clk_reg <= ADC_RESET_VAL;
         adc_data_reg <= ADC_RESET_VAL;
      end else begin
         illum_reg <= ILLUM_SELECT_REQ;
         mirror_rst_n_reg <= MIRROR_ARRAY_RESET_REQ_N;
         adc_clk_reg <= MONITOR_ADC_CLOCK_REQ;
         adc_data_reg <= MONITOR_ADC_DATA_REQ;
      end
   end

   // Everything else floats until running; the board keeps its own pulls meanwhile
   always_ff @(posedge CLK) begin
      if (held_in_reset || !running) begin
         gp_out_reg <= '0;
         gp_oe_reg <= '0;
      end else begin
         gp_out_reg <= GP_OUT_REQ;
         gp_oe_reg <= GP_OE_REQ;
      end
   end

   // Park follows the management controller whenever RESETN is high, power-on reset included; parked while RESETN is low
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         park_reg <= PARK_RESET_VAL;
      end else begin
         park_reg <= !park_sync2_reg;
      end
   end

   // Status and configuration outputs, all registered
   always_ff @(posedge CLK) begin
      if (held_in_reset) begin
         in_reset_reg <= 1'b1;
         init_start_reg <= 1'b0;
         valid_reg <= 1'b0;
         host_two_wire_reg <= 1'b0;
         diag_two_wire_reg <= 1'b0;
         clk_mode_reg <= 1'b0;
         integrity_reg <= 1'b0;
         diag_checksum_reg <= 1'b0;
      end else begin
         in_reset_reg <= 1'b0;
         init_start_reg <= release_ok;
         valid_reg <= strap_if.held;
         host_two_wire_reg <= host_two_wire;
         // The port not chosen for commands becomes the diagnostic port
         diag_two_wire_reg <= strap_if.held && !host_two_wire;
         clk_mode_reg <= clk_mode_alt;
         integrity_reg <= checksum_sel;
         diag_checksum_reg <= FLASH_DIAG_CHECKSUM;
      end
   end

   assign ILLUM_SELECT = illum_reg;
   assign MIRROR_ARRAY_RESET_N = mirror_rst_n_reg;
   assign MONITOR_ADC_CLOCK = adc_clk_reg;
   assign MONITOR_ADC_DATA_OUT = adc_data_reg;
   assign GP_OUT = gp_out_reg;
   assign GP_OE = gp_oe_reg;
   assign IN_RESET = in_reset_reg;
   assign INIT_START = init_start_reg;
   assign STRAPS_VALID = valid_reg;
   assign MIRROR_PARK = park_reg;
   assign HOST_PORT_TWO_WIRE = host_two_wire_reg;
   assign DIAG_PORT_TWO_WIRE = diag_two_wire_reg;
   assign SPI_CLOCK_MODE_ALT = clk_mode_reg;
   assign INTEGRITY_METHOD_SELECT = integrity_reg;
   assign DIAG_INTEGRITY_CHECKSUM = diag_checksum_reg;

endmodule
